// ===== pkg/cdx_pkg.sv
// shared constants and carrier types for the cdr lane splitter
package cdx_pkg;
   localparam int         CLK_MHZ        = 125;
   localparam int         FIFO_WIDTH     = 2;
   localparam int         FIFO_DEPTH     = 32;
   localparam int         RATIO_DIV      = 32;
   localparam int         PPM_TOL        = 1000;
   // short window keeps the first judgement inside a run; tolerance rounds to one count
   localparam int         WIN_REF        = 1000;
   localparam int         WIN_TOL        = (WIN_REF * PPM_TOL + 999_999) / 1_000_000;
   localparam logic [2:0] BAND_OFF_LO    = 3'h0;
   localparam logic [2:0] BAND_OFF_HI    = 3'h7;
   localparam logic       POL_RESET      = 1'h1;
   localparam logic [1:0] GAIN_RESET     = 2'h3;
   localparam logic [7:0] FOLLOW_RESET   = 8'h80;
   localparam int         CP_STEP_00_UA  = 310;
   localparam int         CP_STEP_01_UA  = 270;
   localparam int         CP_STEP_10_UA  = 40;
   localparam int         CP_STEP_11_UA  = 0;

   typedef struct packed {
      logic [2:0] band_sel;
      logic [1:0] cp_gain;
      logic [7:0] follow_cur;
      logic       ref_lvds;
      logic       pol_direct;
      logic       lane_swap;
      logic       full_out_en;
      logic       clk_out_en;
      logic       half_lane_out_enable;
   } cdx_cfg_t;

   typedef struct packed {
      logic lane1;
      logic lane0;
   } cdx_word_t;
endpackage

// ===== core/cdx_fifo.sv
// parameterised valid/ready fifo for the demultiplexed words
`timescale 1ns/10ps
module cdx_fifo #(
   parameter int WIDTH = 2,
   parameter int DEPTH = 32
) (
   // clock and reset
   input  wire logic             i_clk,
   input  wire logic             i_reset_n,
   // fill side
   input  wire logic             i_wr_valid,
   output logic                  o_wr_ready,
   input  wire logic [WIDTH-1:0] i_wr_data,
   // drain side
   output logic                  o_rd_valid,
   input  wire logic             i_rd_ready,
   output logic      [WIDTH-1:0] o_rd_data
);
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0]   cnt;
   } cdx_fifo_st_t;

   cdx_fifo_st_t st_q;
   cdx_fifo_st_t st_d;
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic             wr;
   logic             rd;

   assign o_wr_ready = (st_q.cnt != (AW+1)'(DEPTH));
   assign o_rd_valid = (st_q.cnt != '0);
   assign o_rd_data  = mem_q[st_q.rp];
   assign wr         = i_wr_valid && o_wr_ready;
   assign rd         = o_rd_valid && i_rd_ready;

   always_comb begin
      st_d = st_q;
      if (wr) begin
         st_d.wp = st_q.wp + 1'b1;
      end
      if (rd) begin
         st_d.rp = st_q.rp + 1'b1;
      end
      st_d.cnt = st_q.cnt + (AW+1)'(wr) - (AW+1)'(rd);
   end

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   // storage has no reset; only pointers define content
   always_ff @(posedge i_clk) begin
      if (wr) begin
         mem_q[st_q.wp] <= i_wr_data;
      end
   end

   property p_no_overflow;
      @(posedge i_clk) disable iff (!i_reset_n)
      st_q.cnt <= (AW+1)'(DEPTH);
   endproperty
   a_no_overflow: assert property (p_no_overflow) else $error("fifo count exceeds depth");
endmodule // cdx_fifo

// ===== core/cdx_lock.sv
// frequency lock detector: recovered clock over 32 versus reference
`timescale 1ns/10ps
module cdx_lock (
   // clock and reset
   input  wire logic i_clk,
   input  wire logic i_reset_n,
   // events, all three already in i_clk domain
   input  wire logic i_rec_div_tick,
   input  wire logic i_ref_tick,
   input  wire logic i_osc_off,
   // alarm
   output logic      o_lol
);
   typedef struct packed {
      logic [15:0] ref_cnt;
      logic [15:0] rec_cnt;
      logic        lol;
   } cdx_lock_st_t;

   cdx_lock_st_t st_q;
   cdx_lock_st_t st_d;
   logic [15:0]  diff;

   assign diff  = (st_q.rec_cnt > st_q.ref_cnt) ? st_q.rec_cnt - st_q.ref_cnt
                                                : st_q.ref_cnt - st_q.rec_cnt;
   assign o_lol = st_q.lol;

   always_comb begin
      st_d = st_q;
      st_d.rec_cnt = st_q.rec_cnt + 16'(i_rec_div_tick);
      st_d.ref_cnt = st_q.ref_cnt + 16'(i_ref_tick);
      if (i_osc_off) begin
         st_d.lol     = 1'b1; // see RULE22
         st_d.rec_cnt = '0;
         st_d.ref_cnt = '0;
      end else if (st_q.ref_cnt == 16'(cdx_pkg::WIN_REF)) begin
         // window closed: judge then restart both counts
         st_d.lol     = (diff > 16'(cdx_pkg::WIN_TOL)); // see RULE10 see RULE21
         st_d.rec_cnt = '0;
         st_d.ref_cnt = '0;
      end
   end

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         st_q <= '{ref_cnt: 16'h0000, rec_cnt: 16'h0000, lol: 1'b1};
      end else begin
         st_q <= st_d;
      end
   end

   property p_off_alarm;
      @(posedge i_clk) disable iff (!i_reset_n)
      i_osc_off |=> o_lol;
   endproperty
   a_off_alarm: assert property (p_off_alarm) else $error("alarm not held while oscillator off"); // see RULE22
endmodule // cdx_lock

// ===== core/cdx_top.sv
// cdr lane splitter: retimed serial stream to two half-rate lanes
// What this block does
// RULE1 - split retimed serial bits into two half-rate lanes
// RULE2 - also output the full-rate retimed serial stream
// RULE3 - output half-rate clock aligned with the two lanes
// RULE4 - full-rate, clock and lane outputs each have own enable
// RULE5 - polarity 1 passes data, 0 inverts all three data outputs
// RULE6 - lane swap exchanges which lane carries which word bit
// RULE7 - downstream may toggle swap blindly and find correct order itself
// RULE8 - band codes 1..6 enable an oscillator band, 0 and 7 off
// RULE9 - system supplies reference at one thirty-second of oscillator
// RULE10 - alarm when divided clock differs from reference beyond 1000 ppm
// RULE11 - divide recovered clock by two and demultiplex with it
// RULE12 - two gain bits pick charge pump current step
// RULE13 - follower current byte sets current linearly, higher is more
// RULE14 - reference input mode low is cml, high is lvds
// RULE15 - sample point defaults to middle of each data bit
// RULE16 - frequency loop tracks reference, phase loop tracks data edges
// RULE17 - capture on both half-clock edges forming words ordered by swap
// RULE18 - half clock falling edge coincides with lane transitions; here lanes move at each buffer pop, every cycle while a backlog drains
// RULE19 - each enable bit 1 turns buffer on, 0 turns off
// RULE20 - host holds write enable low while shifting config bits
// RULE21 - lock detect counts both clocks over a window
// RULE22 - alarm held while oscillator is off
`timescale 1ns/10ps
module cdx_top (
   // clock and reset
   input  wire logic             i_clk,
   input  wire logic             i_reset_n,
   // serial line, asynchronous pins
   input  wire logic             i_serial_data_in,
   input  wire logic             i_ref_clock_in,
   // configuration levels
   input  wire cdx_pkg::cdx_cfg_t i_cfg,
   // full-rate retimed output
   output logic                  o_full_data,
   // half-rate outputs
   output logic                  o_half_clock_out,
   output logic                  o_half_lane_zero_out,
   output logic                  o_half_lane_one_out,
   output logic                  o_word_valid,
   input  wire logic             i_word_ready,
   // analog-facing settings
   output logic [2:0]            o_band_onehot_idx,
   output logic                  o_osc_on,
   output logic [8:0]            o_cp_step_ua,
   output logic [7:0]            o_follow_cur,
   output logic                  o_ref_lvds,
   output logic                  o_fifo_stall,
   // alarm
   output logic                  o_loss_of_lock
);
   //////////////////////////////////////////////////////////////////////////
   // decoding helpers

   function automatic logic band_on(input logic [2:0] code);
      band_on = (code != cdx_pkg::BAND_OFF_LO) && (code != cdx_pkg::BAND_OFF_HI);
   endfunction

   function automatic logic [8:0] cp_step(input logic [1:0] g);
      case (g)
         2'h0:    cp_step = 9'(cdx_pkg::CP_STEP_00_UA);
         2'h1:    cp_step = 9'(cdx_pkg::CP_STEP_01_UA);
         2'h2:    cp_step = 9'(cdx_pkg::CP_STEP_10_UA);
         default: cp_step = 9'(cdx_pkg::CP_STEP_11_UA);
      endcase
   endfunction

   //////////////////////////////////////////////////////////////////////////
   // state

   typedef enum logic [0:0] {PH_EVEN, PH_ODD} cdx_phase_t;

   typedef struct packed {
      logic [1:0]  data_sync;
      logic [2:0]  ref_sync;
      logic [4:0]  rec_div;
      logic        rec_tick;
      logic        ref_tick;
      cdx_phase_t  phase;
      logic        first_bit;
      logic        full_data;
      logic        half_clk;
      logic        lane0;
      logic        lane1;
      logic        push;
      logic [1:0]  push_word;
      logic        osc_on;
      logic [2:0]  band;
      logic [8:0]  cp;
      logic [7:0]  follow;
      logic        lvds;
   } cdx_st_t;

   cdx_st_t          st_q;
   cdx_st_t          st_d;
   logic             wr_ready;
   logic             rd_valid;
   logic [1:0]       rd_data;
   logic             lol;
   logic             retimed;
   logic             pol_x;

   // the recovered clock is i_clk; each i_clk edge samples mid-bit
   // after the second sync stage (see RULE15 see RULE16)
   assign retimed = st_q.data_sync[1];
   assign pol_x   = ~i_cfg.pol_direct; // see RULE5

   //////////////////////////////////////////////////////////////////////////
   // next state

   always_comb begin
      st_d           = st_q;
      st_d.data_sync = {st_q.data_sync[0], i_serial_data_in};
      st_d.ref_sync  = {st_q.ref_sync[1:0], i_ref_clock_in};
      // reference edge only from the second stage onward
      st_d.ref_tick  = st_q.ref_sync[1] & ~st_q.ref_sync[2]; // see RULE16
      st_d.rec_div   = st_q.rec_div + 5'h01;
      st_d.rec_tick  = (st_q.rec_div == 5'(cdx_pkg::RATIO_DIV - 1));
      st_d.osc_on    = band_on(i_cfg.band_sel); // see RULE8
      st_d.band      = st_d.osc_on ? i_cfg.band_sel - 3'h1 : 3'h0;
      st_d.cp        = cp_step(i_cfg.cp_gain); // see RULE12
      st_d.follow    = i_cfg.follow_cur; // see RULE13
      st_d.lvds      = i_cfg.ref_lvds; // see RULE14
      st_d.push      = 1'b0;
      // full-rate retimed copy, gated by its enable
      st_d.full_data = i_cfg.full_out_en ? (retimed ^ pol_x) : 1'b0; // see RULE2 see RULE4 see RULE19
      if (st_q.osc_on) begin
         // half clock toggles every bit: divide by two
         st_d.half_clk = ~st_q.half_clk; // see RULE11
         case (st_q.phase)
            PH_EVEN: begin
               st_d.first_bit = retimed; // see RULE17
               st_d.phase     = PH_ODD;
            end
            PH_ODD: begin
               // word lands as half clock falls: lanes change at each buffer pop, on a falling edge only while no backlog is queued
               st_d.push      = 1'b1; // see RULE1 see RULE18
               st_d.push_word = i_cfg.lane_swap ? {st_q.first_bit, retimed}
                                                : {retimed, st_q.first_bit}; // see RULE6 see RULE7
               st_d.phase     = PH_EVEN;
            end
            default: st_d.phase = PH_EVEN;
         endcase
      end else begin
         st_d.half_clk = 1'b0;
         st_d.phase    = PH_EVEN;
      end
      if (rd_valid && i_word_ready) begin
         st_d.lane0 = i_cfg.half_lane_out_enable ? rd_data[0] ^ pol_x : 1'b0; // see RULE4 see RULE5
         st_d.lane1 = i_cfg.half_lane_out_enable ? rd_data[1] ^ pol_x : 1'b0;
      end else if (!i_cfg.half_lane_out_enable) begin
         st_d.lane0 = 1'b0; // see RULE19
         st_d.lane1 = 1'b0;
      end
   end

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // word buffer and lock detector

   cdx_fifo #(
      .WIDTH (cdx_pkg::FIFO_WIDTH),
      .DEPTH (cdx_pkg::FIFO_DEPTH)
   ) u_fifo (
      .i_clk      (i_clk),
      .i_reset_n  (i_reset_n),
      .i_wr_valid (st_q.push),
      .o_wr_ready (wr_ready),
      .i_wr_data  (st_q.push_word),
      .o_rd_valid (rd_valid),
      .i_rd_ready (i_word_ready),
      .o_rd_data  (rd_data)
   );

   cdx_lock u_lock (
      .i_clk          (i_clk),
      .i_reset_n      (i_reset_n),
      .i_rec_div_tick (st_q.rec_tick),
      .i_ref_tick     (st_q.ref_tick),
      .i_osc_off      (!st_q.osc_on),
      .o_lol          (lol)
   );

   //////////////////////////////////////////////////////////////////////////
   // outputs

   assign o_full_data          = st_q.full_data;
   assign o_half_clock_out     = i_cfg.clk_out_en & st_q.half_clk; // see RULE3 see RULE4
   assign o_half_lane_zero_out = st_q.lane0;
   assign o_half_lane_one_out  = st_q.lane1;
   assign o_word_valid         = rd_valid;
   assign o_band_onehot_idx    = st_q.band;
   assign o_osc_on             = st_q.osc_on;
   assign o_cp_step_ua         = st_q.cp;
   assign o_follow_cur         = st_q.follow;
   assign o_ref_lvds           = st_q.lvds;
   // a full buffer drops the word: the serial line cannot be paused
   assign o_fifo_stall         = st_q.push & ~wr_ready;
   assign o_loss_of_lock       = lol; // see RULE10

   //////////////////////////////////////////////////////////////////////////
   // checks

   property p_full_copy;
      @(posedge i_clk) disable iff (!i_reset_n)
      i_cfg.full_out_en |=> (o_full_data == ($past(retimed) ^ ~$past(i_cfg.pol_direct)));
   endproperty
   a_full_copy: assert property (p_full_copy) else $error("full-rate copy wrong"); // see RULE2

   property p_osc_band;
      @(posedge i_clk) disable iff (!i_reset_n)
      ##1 (o_osc_on == band_on($past(i_cfg.band_sel)));
   endproperty
   a_osc_band: assert property (p_osc_band) else $error("band decode wrong"); // see RULE8

   property p_half_div;
      @(posedge i_clk) disable iff (!i_reset_n)
      (st_q.osc_on && $past(st_q.osc_on)) |-> (st_q.half_clk != $past(st_q.half_clk));
   endproperty
   a_half_div: assert property (p_half_div) else $error("half clock not dividing"); // see RULE11

   property p_push_phase;
      @(posedge i_clk) disable iff (!i_reset_n)
      st_q.push |-> (st_q.phase == PH_EVEN) && !st_q.half_clk;
   endproperty
   a_push_phase: assert property (p_push_phase) else $error("word not on falling edge"); // see RULE18

   property p_swap;
      @(posedge i_clk) disable iff (!i_reset_n)
      (st_q.osc_on && st_q.phase == PH_ODD && i_cfg.lane_swap)
         |=> st_q.push_word[1] == $past(st_q.first_bit);
   endproperty
   a_swap: assert property (p_swap) else $error("lane order wrong"); // see RULE6

   property p_lane_off;
      @(posedge i_clk) disable iff (!i_reset_n)
      !i_cfg.half_lane_out_enable |=> !o_half_lane_zero_out && !o_half_lane_one_out;
   endproperty
   a_lane_off: assert property (p_lane_off) else $error("lane not muted"); // see RULE19

   property p_clk_off;
      @(posedge i_clk) disable iff (!i_reset_n)
      !i_cfg.clk_out_en |-> !o_half_clock_out;
   endproperty
   a_clk_off: assert property (p_clk_off) else $error("clock out not muted"); // see RULE4

   property p_cp;
      @(posedge i_clk) disable iff (!i_reset_n)
      (i_cfg.cp_gain == 2'h3) |=> o_cp_step_ua == 9'h000;
   endproperty
   a_cp: assert property (p_cp) else $error("gain step wrong"); // see RULE12

   property p_off_lol;
      @(posedge i_clk) disable iff (!i_reset_n)
      !band_on(i_cfg.band_sel) |-> ##[1:3] o_loss_of_lock;
   endproperty
   a_off_lol: assert property (p_off_lol) else $error("no alarm when oscillator off"); // see RULE10

   property p_no_swap;
      @(posedge i_clk) disable iff (!i_reset_n)
      (st_q.osc_on && st_q.phase == PH_ODD && !i_cfg.lane_swap)
         |=> st_q.push_word[0] == $past(st_q.first_bit);
   endproperty
   a_no_swap: assert property (p_no_swap) else $error("lane order wrong without swap"); // see RULE17

   property p_push_on;
      @(posedge i_clk) disable iff (!i_reset_n)
      st_q.push |-> $past(st_q.osc_on);
   endproperty
   a_push_on: assert property (p_push_on) else $error("word formed while oscillator off"); // see RULE8

   property p_push_rate;
      @(posedge i_clk) disable iff (!i_reset_n)
      st_q.push |=> !st_q.push;
   endproperty
   a_push_rate: assert property (p_push_rate) else $error("words faster than half rate"); // see RULE1

   property p_lane0_pop;
      @(posedge i_clk) disable iff (!i_reset_n)
      (rd_valid && i_word_ready && i_cfg.half_lane_out_enable)
         |=> o_half_lane_zero_out == ($past(rd_data[0]) ^ ~$past(i_cfg.pol_direct));
   endproperty
   a_lane0_pop: assert property (p_lane0_pop) else $error("lane zero value wrong"); // see RULE5

   property p_lane1_pop;
      @(posedge i_clk) disable iff (!i_reset_n)
      (rd_valid && i_word_ready && i_cfg.half_lane_out_enable)
         |=> o_half_lane_one_out == ($past(rd_data[1]) ^ ~$past(i_cfg.pol_direct));
   endproperty
   a_lane1_pop: assert property (p_lane1_pop) else $error("lane one value wrong"); // see RULE5

   property p_lane_hold;
      @(posedge i_clk) disable iff (!i_reset_n)
      (!(rd_valid && i_word_ready) && i_cfg.half_lane_out_enable)
         |=> $stable(o_half_lane_zero_out) && $stable(o_half_lane_one_out);
   endproperty
   a_lane_hold: assert property (p_lane_hold) else $error("lanes moved without a word"); // see RULE1

   property p_half_off;
      @(posedge i_clk) disable iff (!i_reset_n)
      !st_q.osc_on |=> !st_q.half_clk;
   endproperty
   a_half_off: assert property (p_half_off) else $error("half clock runs while off"); // see RULE8

   property p_full_off;
      @(posedge i_clk) disable iff (!i_reset_n)
      !i_cfg.full_out_en |=> !o_full_data;
   endproperty
   a_full_off: assert property (p_full_off) else $error("full-rate output not muted"); // see RULE19

   property p_follow;
      @(posedge i_clk) disable iff (!i_reset_n)
      1'b1 |=> o_follow_cur == $past(i_cfg.follow_cur);
   endproperty
   a_follow: assert property (p_follow) else $error("follower code not passed"); // see RULE13

   property p_ref_mode;
      @(posedge i_clk) disable iff (!i_reset_n)
      1'b1 |=> o_ref_lvds == $past(i_cfg.ref_lvds);
   endproperty
   a_ref_mode: assert property (p_ref_mode) else $error("reference mode not passed"); // see RULE14

   property p_band_idx;
      @(posedge i_clk) disable iff (!i_reset_n)
      band_on(i_cfg.band_sel) |=> o_band_onehot_idx == $past(i_cfg.band_sel) - 3'h1;
   endproperty
   a_band_idx: assert property (p_band_idx) else $error("band index wrong"); // see RULE8

   property p_cp_low;
      @(posedge i_clk) disable iff (!i_reset_n)
      (i_cfg.cp_gain == 2'h0) |=> o_cp_step_ua == 9'(cdx_pkg::CP_STEP_00_UA);
   endproperty
   a_cp_low: assert property (p_cp_low) else $error("lowest gain step wrong"); // see RULE12

   property p_ref_pulse;
      @(posedge i_clk) disable iff (!i_reset_n)
      st_q.ref_tick |=> !st_q.ref_tick;
   endproperty
   a_ref_pulse: assert property (p_ref_pulse) else $error("reference edge not single"); // see RULE16
endmodule // cdx_top

// ===== tb/cdx_sink.sv
// downstream word sink: takes half-rate lanes under a stall control
`timescale 1ns/10ps
module cdx_sink (
   // clock and reset
   input  wire logic i_clk,
   input  wire logic i_reset_n,
   // handshake
   input  wire logic i_word_valid,
   input  wire logic i_stall,
   output logic      o_ready
);
   ////////////////////////////////////////////////////////////////////////////////
   // ready moves just after the edge, so the design never sees it change mid-cycle
   always @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_ready <= 1'h0;
      end else begin
         o_ready <= #1 !i_stall;
      end
   end
   // bit order is not assumed here: the bench judges lane order relatively
endmodule // cdx_sink

// ===== tb/cdx_top_bench.sv
// self-checking bench for the cdr lane splitter
`timescale 1ns/10ps
module cdx_top_bench;
   logic              i_clk;
   logic              i_reset_n;
   logic              i_serial_data_in;
   logic              i_ref_clock_in;
   cdx_pkg::cdx_cfg_t cfg;
   logic              o_full_data;
   logic              o_half_clock_out;
   logic              o_half_lane_zero_out;
   logic              o_half_lane_one_out;
   logic              o_word_valid;
   logic              ready;
   logic              stall;
   logic [2:0]        o_band_onehot_idx;
   logic              o_osc_on;
   logic [8:0]        o_cp_step_ua;
   logic [7:0]        o_follow_cur;
   logic              o_ref_lvds;
   logic              o_fifo_stall;
   logic              o_loss_of_lock;
   logic              alt;
   logic              hold_val;
   int                ref_cnt;
   int                ref_per;
   int                n_fail;
   int                num_checks;
   int                drops;
   int                pops;
   logic [8:0]        cp_tab [4] = '{9'h136, 9'h10e, 9'h028, 9'h000};
   logic              l0;
   logic              l1;
   logic              h0;

   cdx_top dut (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_serial_data_in(i_serial_data_in),
      .i_ref_clock_in(i_ref_clock_in), .i_cfg(cfg), .o_full_data(o_full_data),
      .o_half_clock_out(o_half_clock_out), .o_half_lane_zero_out(o_half_lane_zero_out),
      .o_half_lane_one_out(o_half_lane_one_out), .o_word_valid(o_word_valid),
      .i_word_ready(ready), .o_band_onehot_idx(o_band_onehot_idx), .o_osc_on(o_osc_on),
      .o_cp_step_ua(o_cp_step_ua), .o_follow_cur(o_follow_cur), .o_ref_lvds(o_ref_lvds),
      .o_fifo_stall(o_fifo_stall), .o_loss_of_lock(o_loss_of_lock));
   cdx_sink sink (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_word_valid(o_word_valid),
      .i_stall(stall), .o_ready(ready));

   ////////////////////////////////////////////////////////////////////////////////
   initial i_clk = 1'h0;
   always #4 i_clk = ~i_clk;

   // serial stream and reference at one thirty-second of the bit clock
   // values are taken at the edge and applied 1 ns later, so scenario updates never race them
   always @(posedge i_clk) begin
      i_serial_data_in <= #1 (alt ? ~i_serial_data_in : hold_val);
      ref_cnt = (ref_cnt + 1) % ref_per;
      i_ref_clock_in <= #1 (ref_cnt < ref_per / 2);
   end
   // counted at the edge, where the design samples the handshake
   always @(posedge i_clk) begin
      if (o_fifo_stall === 1'h1) begin
         drops++;
      end
      if (o_word_valid === 1'h1 && ready === 1'h1) begin
         pops++;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic tick(input int n);
      repeat (n) @(posedge i_clk);
      #1;
   endtask
   task automatic cmp(input string name, input logic [8:0] exp, input logic [8:0] got);
      num_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic summarize;
      if (n_fail == 0 && num_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   initial begin
      #(8 * 80000);
      n_fail++;
      summarize();
   end

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      n_fail = 0; num_checks = 0; drops = 0; pops = 0;
      i_reset_n = 1'h0; i_serial_data_in = 1'h0; i_ref_clock_in = 1'h0; ref_cnt = 0;
      ref_per = 32;
      alt = 1'h0; hold_val = 1'h0; stall = 1'h0;
      cfg = '{band_sel: 3'h0, cp_gain: 2'h3, follow_cur: 8'h80, ref_lvds: 1'h0,
              pol_direct: 1'h1, lane_swap: 1'h0, full_out_en: 1'h1, clk_out_en: 1'h1,
              half_lane_out_enable: 1'h1};
      tick(4);
      cmp("lol_in_reset", 9'h001, {8'h00, o_loss_of_lock});
      cmp("full_in_reset", 9'h000, {8'h00, o_full_data});
      i_reset_n = 1'h1;
      // every band code with gain, follower and input mode settings
      for (int c = 0; c < 8; c++) begin
         cfg.band_sel = 3'(c); cfg.cp_gain = 2'(c); cfg.follow_cur = 8'(c * 37);
         cfg.ref_lvds = c[0];
         tick(4);
         cmp("osc_on", {8'h00, (c > 0 && c < 7)}, {8'h00, o_osc_on});
         cmp("band_idx", (c > 0 && c < 7) ? 9'(c - 1) : 9'h000, {6'h00, o_band_onehot_idx});
         if (c == 0 || c == 7) cmp("lol_off", 9'h001, {8'h00, o_loss_of_lock});
         if (c == 0 || c == 7) cmp("half_clk_off", 9'h000, {8'h00, o_half_clock_out});
         cmp("cp_step", cp_tab[c % 4], o_cp_step_ua);
         cmp("follow", {1'h0, 8'(c * 37)}, {1'h0, o_follow_cur});
         cmp("ref_lvds", {8'h00, c[0]}, {8'h00, o_ref_lvds});
      end
      // full-rate path: a one-bit pulse shows three edges later
      cfg.band_sel = 3'h2;
      tick(6);
      hold_val = 1'h1;
      tick(1);
      hold_val = 1'h0;
      tick(1);
      cmp("full_early", 9'h000, {8'h00, o_full_data});
      tick(2);
      cmp("full_pulse", 9'h001, {8'h00, o_full_data});
      cfg.pol_direct = 1'h0;
      tick(5);
      cmp("full_inv", 9'h001, {8'h00, o_full_data});
      cfg.full_out_en = 1'h0;
      tick(2);
      cmp("full_dis", 9'h000, {8'h00, o_full_data});
      cfg.pol_direct = 1'h1; cfg.full_out_en = 1'h1;
      // half clock toggles each bit while enabled
      h0 = o_half_clock_out;
      tick(1);
      cmp("half_clk", {8'h00, ~h0}, {8'h00, o_half_clock_out});
      tick(1);
      cmp("half_clk", {8'h00, h0}, {8'h00, o_half_clock_out});
      cfg.clk_out_en = 1'h0;
      tick(2);
      cmp("half_clk_dis", 9'h000, {8'h00, o_half_clock_out});
      cfg.clk_out_en = 1'h1;
      // alternating bits: lanes hold opposite constants, swap exchanges them
      alt = 1'h1;
      tick(20);
      l0 = o_half_lane_zero_out; l1 = o_half_lane_one_out;
      cmp("lanes_split", {8'h00, ~l0}, {8'h00, l1});
      tick(3);
      cmp("lane0_steady", {8'h00, l0}, {8'h00, o_half_lane_zero_out});
      cfg.lane_swap = 1'h1;
      tick(20);
      cmp("lane0_swap", {8'h00, l1}, {8'h00, o_half_lane_zero_out});
      cmp("lane1_swap", {8'h00, l0}, {8'h00, o_half_lane_one_out});
      cfg.pol_direct = 1'h0;
      tick(20);
      cmp("lane0_inv", {8'h00, ~l1}, {8'h00, o_half_lane_zero_out});
      cfg.half_lane_out_enable = 1'h0;
      tick(3);
      cmp("lanes_dis", 9'h000, {7'h00, o_half_lane_one_out, o_half_lane_zero_out});
      cfg.half_lane_out_enable = 1'h1; cfg.pol_direct = 1'h1;
      // fill the buffer with the sink stalled, stop words, then drain it
      stall = 1'h1;
      tick(120);
      cfg.band_sel = 3'h7;
      tick(6);
      cmp("drops_seen", 9'h001, {8'h00, (drops > 0)});
      stall = 1'h0;
      pops = 0;
      for (int i = 0; i < 60 && !(pops > 0 && o_word_valid !== 1'h1); i++) begin
         tick(1);
      end
      cmp("drained", 9'(cdx_pkg::FIFO_DEPTH), 9'(pops));
      cmp("empty_end", 9'h000, {8'h00, o_word_valid});
      cmp("lol_off_end", 9'h001, {8'h00, o_loss_of_lock});
      // lock detector: a matched reference clears the alarm, a fast one raises it
      cfg.band_sel = 3'h2;
      tick(1000);
      cmp("lol_window", 9'h001, {8'h00, o_loss_of_lock});
      tick(32000);
      cmp("lol_locked", 9'h000, {8'h00, o_loss_of_lock});
      ref_per = 28;
      tick(33000);
      cmp("lol_ppm", 9'h001, {8'h00, o_loss_of_lock});
      summarize();
   end
endmodule // cdx_top_bench
